// ### hdl/mode0_regs.svh
// Constants for the first mode register block: fields, codes, offsets, counts.
// Assumes it is included by the package, by the main module and by the bench.
// Operation
// - Bit 3 picks sequential or interleaved column order within a read burst.
// - Bits 1:0 pick fixed chop-four, fixed eight-beat, or per-command burst length.
// - In per-command mode, address bit 12 with each access picks chop or eight.
// - Eight-beat reads: sequential wraps low bits per half; interleaved is start XOR beat.
// - Chop reads give the first half order, then four undriven slots.
// - Eight-beat writes store columns 0..7; chop writes use column bit 2 only.
// - Fixed chop moves internal write start and recovery reference two clocks earlier.
// - Per-command chop keeps internal write start at the eight-beat point.
// - Read latency bits 2 and 6:4 give whole cycles, no half cycles.
// - First read data comes after additive plus read latency cycles.
// - The loop reset bit clears itself once the reset is carried out.
// - Bits 11:9 give write recovery, which with precharge sets auto-precharge done.
// - Bit 12 low freezes the loop in power-down; slow exit delay follows.
// - Bit 12 high keeps the loop running; short exit delay follows.
`ifndef MODE0_REGS_SVH
`define MODE0_REGS_SVH
`define MR_BT 3
`define MR_CAS_LO 2
`define MR_TM 7
`define MR_DLLRST 8
`define MR_PPD 12
`define MR_BC_BIT 12
`define MR_AP_BIT 10
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
`define ADDR_MODE 12'h000
`define ADDR_LAT 12'h004
`define ADDR_STAT 12'h008
`define LOCK_CYC 512
`define SLOW_EXIT_CYC 10
`define FAST_EXIT_CYC 3
`define PRE_CYC 11
`define BEAT_LAST 3'h7
`define WR_REF_SLOT 3'h7
`define WR_PULLIN 3'h2
`endif

// ### hdl/mode0_pkg.sv
// Types and decode functions shared by the mode register block.
// Assumes the constants header sits beside it.
`include "mode0_regs.svh"
package mode0_pkg;
	typedef logic [2:0] col_t;
	typedef struct packed {
		logic [12:0] mode;
		logic [4:0] add_lat;
		logic [4:0] wl;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic rd_busy;
		logic [5:0] rd_wait;
		logic [2:0] rd_beat;
		logic [2:0] rd_start;
		logic rd_chop;
		logic rd_drive;
		logic [2:0] rd_col;
		logic wr_busy;
		logic [5:0] wr_wait;
		logic [2:0] wr_beat;
		logic [2:0] wr_start;
		logic wr_chop;
		logic wr_fix4;
		logic wr_apre;
		logic wr_valid;
		logic [2:0] wr_col;
		logic wr_ref;
		logic rec_on;
		logic [5:0] rec_cnt;
		logic apre_done;
		logic dll_rst;
		logic [15:0] lock_cnt;
		logic locked;
		logic pwr_down;
		logic exiting;
		logic [15:0] exit_cnt;
		logic frozen;
	} state_t;

	// Read latency from {A6,A5,A4,A2}; the low bit extends the range upward.
	function automatic logic [4:0] cas_decode(input logic [3:0] c);
		cas_decode = 5'h4 + {2'h0, c[3:1]} + (c[0] ? 5'h7 : 5'h0);
	endfunction : cas_decode

	// Write recovery cycles from bits 11:9.
	function automatic logic [4:0] wr_decode(input logic [2:0] c);
		unique case (c)
			3'h0: wr_decode = 5'h10;
			3'h1: wr_decode = 5'h5;
			3'h2: wr_decode = 5'h6;
			3'h3: wr_decode = 5'h7;
			3'h4: wr_decode = 5'h8;
			3'h5: wr_decode = 5'hA;
			3'h6: wr_decode = 5'hC;
			3'h7: wr_decode = 5'hE;
		endcase
	endfunction : wr_decode

	// Chop decision per access; address bit 12 low asks for chop-four.
	function automatic logic chop_pick(input logic [1:0] bl, input logic a12);
		chop_pick = (bl == `BL_FIX4) || ((bl == `BL_OTF) && !a12);
	endfunction : chop_pick
endpackage : mode0_pkg

// ### hdl/burst_column_order.sv
// Column of one burst beat from start column, beat index and mode.
// Assumes a combinational caller that registers the result.
`timescale 1ns/1ps
module burst_column_order
(
	input wire logic [2:0] start,
	input wire logic [2:0] beat,
	input wire logic interleave,
	input wire logic is_write,
	input wire logic chop,
	output logic [2:0] col
);
	// Writes ignore the low start bits, so the order is always ascending.
	always_comb
	begin
		if (is_write)
			col = chop ? {start[2], beat[1:0]} : beat;
		else if (interleave)
			col = start ^ beat;
		else
			col = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
	end
endmodule : burst_column_order

// ### hdl/sdram_mode0_burst_latency.sv
// First mode register of the memory device with burst, latency and loop control.
// Assumes command pins are registered on clk by the caller and APB runs on clk.
`timescale 1ns/1ps
`include "mode0_regs.svh"
module sdram_mode0_burst_latency
#(
	parameter int unsigned LOCK_CYC = `LOCK_CYC,
	parameter int unsigned SLOW_EXIT_CYC = `SLOW_EXIT_CYC,
	parameter int unsigned FAST_EXIT_CYC = `FAST_EXIT_CYC,
	parameter int unsigned PRE_CYC = `PRE_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [15:0] addr,
	input wire logic cke,
	output logic rd_drive,
	output mode0_pkg::col_t rd_col,
	output logic wr_valid,
	output mode0_pkg::col_t wr_col,
	output logic wr_ref,
	output logic apre_done,
	output logic dll_reset_pulse,
	output logic dll_locked,
	output logic dll_frozen,
	output logic exit_busy
);
	import mode0_pkg::*;

	state_t s_q;
	state_t s_d;
	logic is_mrs;
	logic is_rd;
	logic is_wr;
	logic [5:0] read_lat;
	logic [2:0] rd_ord;
	logic [2:0] wr_ord;
	logic [2:0] ref_slot;
	logic [4:0] cas_lat;

	// Command decode on the registered pins.
	assign is_mrs = !cs_n && !ras_n && !cas_n && !we_n && (ba == 3'h0);
	assign is_rd = !cs_n && ras_n && !cas_n && we_n;
	assign is_wr = !cs_n && ras_n && !cas_n && !we_n;
	assign cas_lat = cas_decode({s_q.mode[6:4], s_q.mode[`MR_CAS_LO]});
	assign read_lat = 6'(s_q.add_lat) + 6'(cas_lat);
	// Fixed chop pulls the internal write start in; per-command chop does not.
	assign ref_slot = s_q.wr_fix4 ? (`WR_REF_SLOT - `WR_PULLIN) : `WR_REF_SLOT;

	burst_column_order u_rd_order
	(
		.start(s_q.rd_start),
		.beat(s_q.rd_beat),
		.interleave(s_q.mode[`MR_BT]),
		.is_write(1'b0),
		.chop(s_q.rd_chop),
		.col(rd_ord)
	);

	burst_column_order u_wr_order
	(
		.start(s_q.wr_start),
		.beat(s_q.wr_beat),
		.interleave(s_q.mode[`MR_BT]),
		.is_write(1'b1),
		.chop(s_q.wr_chop),
		.col(wr_ord)
	);

	// Next state of the whole block; pulses default low each cycle.
	always_comb
	begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.rd_drive = 1'b0;
		s_d.wr_valid = 1'b0;
		s_d.wr_ref = 1'b0;
		s_d.apre_done = 1'b0;
		s_d.dll_rst = 1'b0;
		// APB setup cycle prepares the answer so the access phase lasts one cycle.
		if (psel && !penable)
		begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0;
			unique case (paddr)
				`ADDR_MODE: s_d.prdata = {19'h0, s_q.mode};
				`ADDR_LAT: s_d.prdata = {22'h0, s_q.wl, s_q.add_lat};
				`ADDR_STAT: s_d.prdata = {22'h0, cas_lat, s_q.exiting, s_q.pwr_down, s_q.frozen,
					s_q.locked, s_q.mode[`MR_TM]};
				default: s_d.pslverr = 1'b1;
			endcase
		end
		// Writes land only on the completing access edge.
		if (psel && penable && s_q.pready && pwrite && (paddr == `ADDR_LAT))
		begin
			s_d.add_lat = pwdata[4:0];
			s_d.wl = pwdata[9:5];
		end
		// The loop reset bit is cleared the cycle after the reset is issued.
		if (s_q.dll_rst)
			s_d.mode[`MR_DLLRST] = 1'b0;
		if (is_mrs)
		begin
			s_d.mode = addr[12:0];
			if (addr[`MR_DLLRST])
			begin
				s_d.dll_rst = 1'b1;
				s_d.lock_cnt = 16'(LOCK_CYC);
				s_d.locked = 1'b0;
			end
		end
		// Lock is reported only after a loop reset, never straight out of reset.
		else if (!s_q.dll_rst && (s_q.lock_cnt != 16'h0))
		begin
			s_d.lock_cnt = s_q.lock_cnt - 16'h1;
			if (s_q.lock_cnt == 16'h1)
				s_d.locked = 1'b1;
		end
		// One read in flight; a read during a burst is ignored.
		if (!s_q.rd_busy)
		begin
			if (is_rd)
			begin
				s_d.rd_busy = 1'b1;
				s_d.rd_wait = read_lat - 6'h1;
				s_d.rd_beat = 3'h0;
				s_d.rd_start = addr[2:0];
				s_d.rd_chop = chop_pick(s_q.mode[1:0], addr[`MR_BC_BIT]);
			end
		end
		else if (s_q.rd_wait != 6'h0)
			s_d.rd_wait = s_q.rd_wait - 6'h1;
		else
		begin
			s_d.rd_drive = !(s_q.rd_chop && s_q.rd_beat[2]);
			s_d.rd_col = rd_ord;
			s_d.rd_beat = s_q.rd_beat + 3'h1;
			if (s_q.rd_beat == `BEAT_LAST)
				s_d.rd_busy = 1'b0;
		end
		// Recovery countdown runs before a new load so the load wins.
		if (s_q.rec_on)
		begin
			if (s_q.rec_cnt == 6'h0)
			begin
				s_d.apre_done = 1'b1;
				s_d.rec_on = 1'b0;
			end
			else
				s_d.rec_cnt = s_q.rec_cnt - 6'h1;
		end
		if (!s_q.wr_busy)
		begin
			if (is_wr)
			begin
				s_d.wr_busy = 1'b1;
				s_d.wr_wait = 6'(s_q.wl) - 6'h1;
				s_d.wr_beat = 3'h0;
				s_d.wr_start = addr[2:0];
				s_d.wr_chop = chop_pick(s_q.mode[1:0], addr[`MR_BC_BIT]);
				s_d.wr_fix4 = (s_q.mode[1:0] == `BL_FIX4);
				s_d.wr_apre = addr[`MR_AP_BIT];
			end
		end
		else if (s_q.wr_wait != 6'h0)
			s_d.wr_wait = s_q.wr_wait - 6'h1;
		else
		begin
			s_d.wr_valid = !(s_q.wr_chop && s_q.wr_beat[2]);
			s_d.wr_col = wr_ord;
			s_d.wr_beat = s_q.wr_beat + 3'h1;
			if (s_q.wr_beat == ref_slot)
			begin
				s_d.wr_ref = 1'b1;
				s_d.rec_on = s_q.wr_apre;
				s_d.rec_cnt = 6'(wr_decode(s_q.mode[11:9])) + 6'(PRE_CYC);
			end
			if (s_q.wr_beat == `BEAT_LAST)
				s_d.wr_busy = 1'b0;
		end
		// Power-down entry when clock enable drops with no burst running.
		if (s_q.exiting)
		begin
			if (s_q.exit_cnt == 16'h0)
				s_d.exiting = 1'b0;
			else
				s_d.exit_cnt = s_q.exit_cnt - 16'h1;
		end
		if (!s_q.pwr_down && !cke && !s_q.rd_busy && !s_q.wr_busy)
			s_d.pwr_down = 1'b1;
		else if (s_q.pwr_down && cke)
		begin
			s_d.pwr_down = 1'b0;
			s_d.exiting = 1'b1;
			s_d.exit_cnt = s_q.mode[`MR_PPD] ? 16'(FAST_EXIT_CYC) : 16'(SLOW_EXIT_CYC);
		end
		s_d.frozen = s_d.pwr_down && !s_q.mode[`MR_PPD];
	end

	// Single register for all state; synchronous reset to zero.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register.
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign rd_drive = s_q.rd_drive;
	assign rd_col = s_q.rd_col;
	assign wr_valid = s_q.wr_valid;
	assign wr_col = s_q.wr_col;
	assign wr_ref = s_q.wr_ref;
	assign apre_done = s_q.apre_done;
	assign dll_reset_pulse = s_q.dll_rst;
	assign dll_locked = s_q.locked;
	assign dll_frozen = s_q.frozen;
	assign exit_busy = s_q.exiting;

	property p_dll_selfclear;
		@(posedge clk) disable iff (!rst_n)
		(s_q.dll_rst && !is_mrs) |=> !s_q.mode[`MR_DLLRST];
	endproperty
	a_dll_selfclear: assert property (p_dll_selfclear) else $error("loop reset bit stuck");

	property p_mrs_bl;
		@(posedge clk) disable iff (!rst_n)
		is_mrs |=> s_q.mode[1:0] == $past(addr[1:0]) && s_q.mode[`MR_BT] == $past(addr[3]);
	endproperty
	a_mrs_bl: assert property (p_mrs_bl) else $error("burst fields not captured");

	property p_fix4_chop;
		@(posedge clk) disable iff (!rst_n)
		(is_rd && !s_q.rd_busy && s_q.mode[1:0] == `BL_FIX4) |=> s_q.rd_chop;
	endproperty
	a_fix4_chop: assert property (p_fix4_chop) else $error("fixed chop not applied");

	property p_otf_chop;
		@(posedge clk) disable iff (!rst_n)
		(is_rd && !s_q.rd_busy && s_q.mode[1:0] == `BL_OTF) |=> s_q.rd_chop == !$past(addr[12]);
	endproperty
	a_otf_chop: assert property (p_otf_chop) else $error("per-command chop wrong");

	property p_rd_latency;
		@(posedge clk) disable iff (!rst_n)
		(is_rd && !s_q.rd_busy && read_lat == 6'h6) |-> ##1 !s_q.rd_drive [*6] ##1 s_q.rd_drive;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("first read beat late or early");

	property p_chop_hiz;
		@(posedge clk) disable iff (!rst_n)
		(s_q.rd_busy && s_q.rd_wait == 6'h0 && s_q.rd_chop && s_q.rd_beat[2]) |=> !s_q.rd_drive;
	endproperty
	a_chop_hiz: assert property (p_chop_hiz) else $error("chop read drove late slot");

	property p_interleave;
		@(posedge clk) disable iff (!rst_n)
		(s_q.rd_busy && s_q.rd_wait == 6'h0 && s_q.mode[`MR_BT])
			|=> s_q.rd_col == ($past(s_q.rd_start) ^ $past(s_q.rd_beat));
	endproperty
	a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

	property p_wr_pullin;
		@(posedge clk) disable iff (!rst_n)
		(s_q.wr_busy && s_q.wr_wait == 6'h0 && s_q.wr_fix4 && s_q.wr_beat == 3'h5) |=> s_q.wr_ref;
	endproperty
	a_wr_pullin: assert property (p_wr_pullin) else $error("fixed chop write start not early");

	property p_wr8_order;
		@(posedge clk) disable iff (!rst_n)
		(s_q.wr_busy && s_q.wr_wait == 6'h0 && !s_q.wr_chop) |=> s_q.wr_col == $past(s_q.wr_beat);
	endproperty
	a_wr8_order: assert property (p_wr8_order) else $error("eight-beat write order wrong");

	property p_frozen;
		@(posedge clk) disable iff (!rst_n)
		(s_q.pwr_down && cke && !s_q.mode[`MR_PPD]) |=> s_q.exiting && !s_q.frozen;
	endproperty
	a_frozen: assert property (p_frozen) else $error("slow exit not started");
endmodule : sdram_mode0_burst_latency

// ### tb/ctrl_model.sv
// Controller side of the command bus: mode set, read and write commands.
// Assumes the caller waits for loop lock and exit delays before issuing reads.
`timescale 1ns/1ps
module ctrl_model
(
	input wire logic clk,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [15:0] addr
);
	// Bus starts deselected so the device sees no command before reset ends.
	initial
	begin
		cs_n = 1'b1;
		ras_n = 1'b1;
		cas_n = 1'b1;
		we_n = 1'b1;
		ba = 3'h0;
		addr = 16'h0000;
	end

	// Kind 0 is a mode set, 1 a read, 2 a write; held for exactly one edge.
	task automatic issue(input int kind, input logic [15:0] a);
		@(posedge clk);
		cs_n <= 1'b0;
		ras_n <= (kind != 0);
		cas_n <= 1'b0;
		we_n <= (kind == 1);
		ba <= 3'h0;
		addr <= (kind == 0) ? {3'h0, a[12:8], 1'b0, a[6:0]} : a;
		@(posedge clk);
		cs_n <= 1'b1;
		ras_n <= 1'b1;
		cas_n <= 1'b1;
		we_n <= 1'b1;
		// Released lines toggle so that a stale value is never mistaken for a command.
		ba <= ~ba;
		addr <= ~addr;
	endtask : issue
endmodule : ctrl_model

// ### tb/test_sdram_mode0_burst_latency.sv
// Self-checking bench: APB master, controller model and a reference model.
// Assumes the design header and package are compiled first.
`timescale 1ns/1ps
`include "mode0_regs.svh"
module test_sdram_mode0_burst_latency;
	import mode0_pkg::*;
	localparam int LOCK = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic cke = 1'b1;
	logic [31:0] prdata, rdata_q;
	logic pready, pslverr, err_q, cs_n, ras_n, cas_n, we_n, rd_drive, wr_valid;
	logic wr_ref, apre_done, dll_reset_pulse, dll_locked, dll_frozen, exit_busy;
	logic [2:0] ba;
	logic [15:0] addr;
	col_t rd_col, wr_col;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	integer seed = 15410;
	int wrt[8] = '{16, 5, 6, 7, 8, 10, 12, 14};

	sdram_mode0_burst_latency #(.LOCK_CYC(LOCK)) u_dut (.clk, .rst_n, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cs_n, .ras_n, .cas_n,
		.we_n, .ba, .addr, .cke, .rd_drive, .rd_col, .wr_valid, .wr_col, .wr_ref,
		.apre_done, .dll_reset_pulse, .dll_locked, .dll_frozen, .exit_busy);
	ctrl_model u_ctl (.clk, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

	// Free-running 100 MHz clock.
	initial
		forever #5 clk = ~clk;

	// Hang guard; far above the thousand or so cycles the tests need.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			$display("Error at %0t: timeout", $time);
			close_out;
		end
	end

	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_col(input col_t got, input col_t exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: column %0d expected %0d", $time, got, exp);
		end
	endtask : chk_col

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// Outputs are registered, so right after an edge they still show what that edge sampled.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			miscompares++;
			$display("Error at %0t: no bus answer", $time);
		end
		rdata_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic int exp_col(input int s, input int b, input int il, input int wr,
		input int ch);
		if (wr != 0)
			return (ch != 0) ? ((s & 4) | b) : b;
		if (il != 0)
			return s ^ b;
		return ((s ^ b) & 4) | ((s + b) & 3);
	endfunction : exp_col

	// Read then write two edges later; slots counted from the write command edge.
	task automatic burst(input int bl, input int a12, input int bt);
		int add_lat, wl, cas_code, wr, st, ap, read_lat, ch, ref_at, kr, kw;
		logic [15:0] m;
		logic de, dw;
		add_lat = {$random(seed)} % 4;
		wl = 1 + {$random(seed)} % 4;
		cas_code = {$random(seed)} % 16;
		wr = {$random(seed)} % 8; // Every code gives five cycles or more.
		st = {$random(seed)} % 8;
		ap = {$random(seed)} % 2;
		// The first burst pins total latency at six cycles so the latency assertion is reached.
		add_lat = (bl == 0 && a12 == 0 && bt == 0) ? 2 : add_lat;
		cas_code = (bl == 0 && a12 == 0 && bt == 0) ? 0 : cas_code;
		m = {4'h0, 3'(wr), 2'h0, 3'(cas_code >> 1), 1'(bt), 1'(cas_code), 2'(bl)};
		apb(1'b1, 12'h004, 32'(wl * 32 + add_lat));
		u_ctl.issue(0, m);
		apb(1'b0, 12'h000, 32'h0);
		chk_word(rdata_q, 32'(m));
		read_lat = add_lat + 4 + (cas_code >> 1) + ((cas_code & 1) * 7);
		ch = (bl == 2 || (bl == 1 && a12 == 0));
		ref_at = wl + ((bl == 2) ? 5 : 7);
		u_ctl.issue(1, 16'(a12 * 4096 + st));
		u_ctl.issue(2, 16'(a12 * 4096 + ap * 1024 + st));
		for (int k = 1; k < 46; k++)
		begin
			@(posedge clk);
			#1;
			kr = k + 2 - read_lat;
			kw = k - wl;
			de = kr >= 0 && kr < ((ch != 0) ? 4 : 8);
			dw = kw >= 0 && kw < ((ch != 0) ? 4 : 8);
			chk_bit(rd_drive, de);
			if (de)
				chk_col(rd_col, col_t'(exp_col(st, kr, bt, 0, ch)));
			chk_bit(wr_valid, dw);
			if (dw)
				chk_col(wr_col, col_t'(exp_col(st, kw, bt, 1, ch)));
			chk_bit(wr_ref, k == ref_at);
			chk_bit(apre_done, ap == 1 && k == ref_at + wrt[wr] + `PRE_CYC + 1);
		end
		$display("burst test done: length %0d select %0d type %0d", bl, a12, bt);
	endtask : burst

	// Precharge power-down entry and exit with the chosen loop handling.
	task automatic power(input int ppd);
		int n;
		n = 0;
		u_ctl.issue(0, 16'(ppd * 4096));
		@(posedge clk);
		cke <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk_bit(dll_frozen, ppd == 0);
		@(posedge clk);
		cke <= 1'b1;
		// The controller holds off commands while the exit delay runs.
		repeat (20)
		begin
			@(posedge clk);
			#1;
			n += int'(exit_busy);
		end
		chk_word(32'(n), 32'((ppd != 0) ? `FAST_EXIT_CYC + 1 : `SLOW_EXIT_CYC + 1));
		$display("power-down test done: fast %0d", ppd);
	endtask : power

	// Main sequence: reset, registers, loop reset, bursts, power-down.
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk_word(rdata_q, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk_bit(err_q, 1'b1);
		chk_word(rdata_q, 32'h0);
		// Latency code zero decodes to four cycles; no lock before any loop reset.
		apb(1'b0, 12'h008, 32'h0);
		chk_word(rdata_q, 32'h80);
		$display("register test done");
		u_ctl.issue(0, 16'h0100);
		// The pulse stands in the cycle right after the mode set edge, so look at once.
		for (int k = 0; k < 9; k++)
		begin
			if (k != 0)
				@(posedge clk);
			#1;
			chk_bit(dll_reset_pulse, k == 0);
			chk_bit(dll_locked, k >= LOCK + 1);
		end
		apb(1'b0, 12'h000, 32'h0);
		chk_word(rdata_q, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk_word(rdata_q, 32'h82);
		$display("loop reset test done");
		// Reads start only after lock has been seen above.
		for (int bl = 0; bl < 4; bl++)
			for (int a = 0; a < 2; a++)
				for (int bt = 0; bt < 2; bt++)
					burst(bl, a, bt);
		power(0);
		power(1);
		close_out;
	end
endmodule : test_sdram_mode0_burst_latency
